// [src/nip_map.svh]
// register offsets, field positions and reset values of the node identity block
`ifndef NIP_MAP_SVH
`define NIP_MAP_SVH
`define NIP_OFF_NODE_ID    12'h0e8
`define NIP_OFF_PHY_MBOX   12'h0ec
`define NIP_OFF_INT_STAT   12'h0f8
`define NIP_OFF_INT_MASK   12'h0fc
`define NIP_BIT_ID_VALID   31
`define NIP_BIT_ROOT       30
`define NIP_BIT_CPS        27
`define NIP_BIT_RD_DONE    31
`define NIP_BIT_RD_REQ     15
`define NIP_BIT_WR_REQ     14
`define NIP_BUS_IDX_RST    10'h3ff
`define NIP_NODE_UNSET     6'h3f
`define NIP_REQ_BITS       5'd16
`endif

// [src/nip_pkg.sv]
// types of the node identity and phy mailbox block
package nip_pkg;
	typedef enum logic [2:0] {
		NIP_IDLE  = 3'b001,
		NIP_SHIFT = 3'b010,
		NIP_DONE  = 3'b100
	} nip_state_e;
	typedef struct packed {
		nip_state_e  st;
		logic        id_valid;
		logic        root;
		logic        cable_power_ok;
		logic [9:0]  bus_index;
		logic [5:0]  node_index;
		logic        rd_complete;
		logic [3:0]  rd_reg_index;
		logic [7:0]  rd_value;
		logic        rd_req;
		logic        wr_req;
		logic [3:0]  target_index;
		logic [7:0]  write_value;
		logic [15:0] shift;
		logic [4:0]  bit_cnt;
		logic        lreq;
		logic [2:0]  int_stat;
		logic [2:0]  int_mask;
		logic [31:0] prdata;
	} nip_state_s;
endpackage : nip_pkg

// [src/nip_node_phy_regs.sv]
// node identity register, phy register mailbox and link request serialiser
//==========================================================
// What this block does
// - bus reset clears valid; new node sets
// - root bit set at bus reset when phy reports root
// - cable power bit follows phy status
// - node register reserved bits read zero
// - bus index writable, updatable, resets all ones
// - node id is bus index over node
// - node index loaded after self id, read-only
// - read or write request clears read complete
// - received phy register transfer sets read complete
// - capture received register address
// - capture received register contents
// - read request cleared once sent
// - write request cleared once sent
// - target index field, reset zero
// - write value field, ignored on reads, reset zero
// - mailbox reserved bits read zero
`timescale 1ns/100ps
`include "nip_map.svh"
module nip_node_phy_regs
	import nip_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        bus_reset,
	input  wire logic        self_id_done,
	input  wire logic [5:0]  phy_node_number,
	input  wire logic        phy_is_root,
	input  wire logic        phy_cable_power_ok,
	input  wire logic        phy_reg_valid,
	input  wire logic [3:0]  phy_reg_index,
	input  wire logic [7:0]  phy_reg_value,
	output logic             link_request,
	output logic [15:0]      node_id,
	output logic             node_id_valid,
	output logic             irq
);
	//==========================================================
	// state
	nip_state_s r_r;
	nip_state_s r_nxt;
	logic       acc;
	logic       wr;
	logic       hit;
	logic [31:0] node_word;
	logic [31:0] mbox_word;

	assign acc = psel & penable;
	assign wr  = acc & pwrite;
	assign hit = (paddr == `NIP_OFF_NODE_ID) | (paddr == `NIP_OFF_PHY_MBOX) |
		(paddr == `NIP_OFF_INT_STAT) | (paddr == `NIP_OFF_INT_MASK);

	always_comb begin
		node_word = 32'h0000_0000;
		node_word[`NIP_BIT_ID_VALID] = r_r.id_valid;
		node_word[`NIP_BIT_ROOT]     = r_r.root;
		node_word[`NIP_BIT_CPS]      = r_r.cable_power_ok;
		node_word[15:0] = {r_r.bus_index, r_r.node_index};
		mbox_word = 32'h0000_0000;
		mbox_word[`NIP_BIT_RD_DONE] = r_r.rd_complete;
		mbox_word[27:24] = r_r.rd_reg_index;
		mbox_word[23:16] = r_r.rd_value;
		mbox_word[`NIP_BIT_RD_REQ] = r_r.rd_req;
		mbox_word[`NIP_BIT_WR_REQ] = r_r.wr_req;
		mbox_word[11:8] = r_r.target_index;
		mbox_word[7:0]  = r_r.write_value;
	end

	//==========================================================
	// next state
	always_comb begin
		r_nxt = r_r;
		r_nxt.prdata = 32'h0000_0000;
		// link-side hardware updates
		if (bus_reset) begin
			r_nxt.id_valid = 1'b0;
			if (phy_is_root)
				r_nxt.root = 1'b1;
			else
				r_nxt.root = 1'b0;
		end
		if (self_id_done) begin
			r_nxt.node_index = phy_node_number;
			r_nxt.id_valid   = 1'b1;
		end
		r_nxt.cable_power_ok = phy_cable_power_ok;
		// software writes; hardware sets below override the clears
		if (wr) begin
			case (paddr)
				`NIP_OFF_NODE_ID: begin
					if (pstrb[1])
						r_nxt.bus_index[9:2] = pwdata[15:8];
					if (pstrb[0])
						r_nxt.bus_index[1:0] = pwdata[7:6];
				end
				`NIP_OFF_PHY_MBOX: begin
					if (pstrb[1]) begin
						r_nxt.target_index = pwdata[11:8];
						// a pending request is never overwritten before it is sent
						if (r_r.st == NIP_IDLE && !(r_r.rd_req | r_r.wr_req)) begin
							r_nxt.rd_req = pwdata[`NIP_BIT_RD_REQ];
							r_nxt.wr_req = pwdata[`NIP_BIT_WR_REQ];
							if (pwdata[`NIP_BIT_RD_REQ] | pwdata[`NIP_BIT_WR_REQ])
								r_nxt.rd_complete = 1'b0;
						end
					end
					if (pstrb[0])
						r_nxt.write_value = pwdata[7:0];
				end
				`NIP_OFF_INT_STAT: r_nxt.int_stat = r_r.int_stat & ~pwdata[2:0];
				`NIP_OFF_INT_MASK: r_nxt.int_mask = pwdata[2:0];
				default: ;
			endcase
		end
		// request serialiser: a request bit stays set until it is fully shifted out
		case (r_r.st)
			NIP_IDLE: begin
				r_nxt.lreq = 1'b0;
				if (r_r.rd_req | r_r.wr_req) begin
					// start, rd/wr flag, 4-bit index, 8-bit value (zeros on reads)
					r_nxt.shift = {1'b1, r_r.wr_req, r_r.target_index,
						r_r.wr_req ? r_r.write_value : 8'h00, 2'b00};
					r_nxt.bit_cnt = `NIP_REQ_BITS;
					r_nxt.st = NIP_SHIFT;
				end
			end
			NIP_SHIFT: begin
				r_nxt.lreq  = r_r.shift[15];
				r_nxt.shift = {r_r.shift[14:0], 1'b0};
				r_nxt.bit_cnt = r_r.bit_cnt - 5'd1;
				if (r_r.bit_cnt == 5'd1)
					r_nxt.st = NIP_DONE;
			end
			NIP_DONE: begin
				r_nxt.lreq   = 1'b0;
				r_nxt.rd_req = 1'b0;
				r_nxt.wr_req = 1'b0;
				r_nxt.int_stat[1] = 1'b1;
				r_nxt.st = NIP_IDLE;
			end
			default: r_nxt.st = NIP_IDLE;
		endcase
		if (phy_reg_valid) begin
			r_nxt.rd_complete  = 1'b1;
			r_nxt.rd_reg_index = phy_reg_index;
			r_nxt.rd_value     = phy_reg_value;
			r_nxt.int_stat[0]  = 1'b1;
		end
		// events set over a same-cycle clear
		if (bus_reset)
			r_nxt.int_stat[2] = 1'b1;
		if (acc & ~pwrite) begin
			case (paddr)
				`NIP_OFF_NODE_ID:  r_nxt.prdata = node_word;
				`NIP_OFF_PHY_MBOX: r_nxt.prdata = mbox_word;
				`NIP_OFF_INT_STAT: r_nxt.prdata = {29'h0, r_r.int_stat};
				`NIP_OFF_INT_MASK: r_nxt.prdata = {29'h0, r_r.int_mask};
				default:           r_nxt.prdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_r <= '0;
			r_r.st <= NIP_IDLE;
			r_r.bus_index <= `NIP_BUS_IDX_RST;
			r_r.node_index <= `NIP_NODE_UNSET;
		end else begin
			r_r <= r_nxt;
		end
	end

	//==========================================================
	// outputs; read data lands one cycle after the access phase opens
	logic rd_wait_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rd_wait_r <= 1'b0;
		else
			rd_wait_r <= acc & ~pwrite & ~rd_wait_r;
	end
	// writes finish at once, reads take one wait state so prdata is registered
	assign pready  = acc & (pwrite | rd_wait_r);
	assign pslverr = acc & ~hit;
	assign prdata  = r_r.prdata;
	assign link_request  = r_r.lreq;
	assign node_id       = {r_r.bus_index, r_r.node_index};
	assign node_id_valid = r_r.id_valid;
	assign irq = |(r_r.int_stat & r_r.int_mask);

	//==========================================================
	// checks
	req_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(r_r.st == NIP_DONE) |=> !r_r.rd_req && !r_r.wr_req)
		else $error("request bit not cleared after send");
	done_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		phy_reg_valid |=> r_r.rd_complete)
		else $error("read complete not set");
	done_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == `NIP_OFF_PHY_MBOX && pstrb[1] && r_r.st == NIP_IDLE &&
		!r_r.rd_req && !r_r.wr_req &&
		pwdata[15] && !phy_reg_valid) |=> !r_r.rd_complete)
		else $error("read complete not cleared");
	capture_a: assert property (@(posedge pclk) disable iff (!presetn)
		phy_reg_valid |=> r_r.rd_reg_index == $past(phy_reg_index) &&
		r_r.rd_value == $past(phy_reg_value))
		else $error("phy transfer not captured");
	id_valid_a: assert property (@(posedge pclk) disable iff (!presetn)
		(bus_reset && !self_id_done) |=> !node_id_valid)
		else $error("valid not cleared on bus reset");
	node_load_a: assert property (@(posedge pclk) disable iff (!presetn)
		self_id_done |=> node_id[5:0] == $past(phy_node_number) && node_id_valid)
		else $error("node index not loaded");
	cps_track_a: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> r_r.cable_power_ok == $past(phy_cable_power_ok))
		else $error("cable power bit stale");
	root_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		(bus_reset && phy_is_root) |=> r_r.root)
		else $error("root bit not set");
	serial_len_a: assert property (@(posedge pclk) disable iff (!presetn)
		(r_r.st == NIP_IDLE && (r_r.rd_req || r_r.wr_req)) |=> ##16 r_r.st == NIP_DONE)
		else $error("request length wrong");
	reserved_a: assert property (@(posedge pclk) disable iff (!presetn)
		node_word[29:28] == 2'b00 && node_word[26:16] == 11'h000 &&
		mbox_word[30:28] == 3'b000 && mbox_word[13:12] == 2'b00)
		else $error("reserved bits nonzero");
	read_c:   cover property (@(posedge pclk) r_r.rd_req && r_r.st == NIP_DONE);
	write_c:  cover property (@(posedge pclk) r_r.wr_req && r_r.st == NIP_DONE);
	rx_c:     cover property (@(posedge pclk) phy_reg_valid && irq);
	breset_c: cover property (@(posedge pclk) bus_reset ##[1:20] self_id_done);

	//==========================================================
	// request age; a request never sent would hang software polling forever
	logic [4:0] req_age_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			req_age_r <= 5'h00;
		else if (!(r_r.rd_req | r_r.wr_req))
			req_age_r <= 5'h00;
		else if (req_age_r != 5'h1f)
			req_age_r <= req_age_r + 5'h01;
	end

	//==========================================================
	// register and link checks

	req_age_a: assert property (@(posedge pclk) disable iff (!presetn)
		req_age_r <= 5'h12)
		else $error("request pending too long");

	valid_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		self_id_done |=> node_id_valid)
		else $error("valid not set after self id");

	root_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(bus_reset && !phy_is_root) |=> !r_r.root)
		else $error("root bit not cleared");

	root_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		!bus_reset |=> r_r.root == $past(r_r.root))
		else $error("root bit changed outside bus reset");

	node_ro_a: assert property (@(posedge pclk) disable iff (!presetn)
		!self_id_done |=> node_id[5:0] == $past(node_id[5:0]))
		else $error("node index changed without self id");

	bus_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == `NIP_OFF_NODE_ID && pstrb == 4'hf) |=> node_id[15:6] == $past(pwdata[15:6]))
		else $error("bus index not written");

	bus_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		!(wr && paddr == `NIP_OFF_NODE_ID) |=> node_id[15:6] == $past(node_id[15:6]))
		else $error("bus index changed without write");

	target_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == `NIP_OFF_PHY_MBOX && pstrb[1]) |=> r_r.target_index == $past(pwdata[11:8]))
		else $error("target index not written");

	value_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == `NIP_OFF_PHY_MBOX && pstrb[0]) |=> r_r.write_value == $past(pwdata[7:0]))
		else $error("write value not written");

	read_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		(r_r.st == NIP_SHIFT && !r_r.wr_req && r_r.bit_cnt <= 5'd10) |=> !link_request)
		else $error("read frame carries data bits");

	frame_tail_a: assert property (@(posedge pclk) disable iff (!presetn)
		(r_r.st == NIP_SHIFT && r_r.bit_cnt <= 5'd2) |=> !link_request)
		else $error("frame tail not zero");

	start_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
		(r_r.st == NIP_SHIFT && r_r.bit_cnt == 5'd16) |=> link_request)
		else $error("start bit missing");

	wr_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		(r_r.st == NIP_SHIFT && r_r.bit_cnt == 5'd15) |=> link_request == $past(r_r.wr_req))
		else $error("direction bit wrong");

	line_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
		(r_r.st != NIP_SHIFT) |=> !link_request)
		else $error("link request outside frame");

	req_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(r_r.st == NIP_SHIFT) |-> (r_r.rd_req || r_r.wr_req))
		else $error("request bit lost while sending");

	stat_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		bus_reset |=> r_r.int_stat[2])
		else $error("bus reset status not set");

	stat_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == `NIP_OFF_INT_STAT && pwdata[0] && !phy_reg_valid) |=> !r_r.int_stat[0])
		else $error("status bit not cleared");

	mask_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == `NIP_OFF_INT_MASK) |=> r_r.int_mask == $past(pwdata[2:0]))
		else $error("mask not written");

	wr_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && pwrite) |-> pready)
		else $error("write not answered at once");

	rd_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && !pwrite && !rd_wait_r) |-> !pready)
		else $error("read wait state missing");

	rdata_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
		!(psel && penable) |=> prdata == 32'h0000_0000)
		else $error("read data outside access");

	done_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(r_r.rd_complete && !wr) |=> r_r.rd_complete)
		else $error("read complete dropped");

	rx_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		!phy_reg_valid |=> r_r.rd_reg_index == $past(r_r.rd_reg_index) &&
		r_r.rd_value == $past(r_r.rd_value))
		else $error("captured transfer changed");
endmodule : nip_node_phy_regs

// [tb/nip_phy_model.sv]
// behavioural physical-layer chip: decodes link requests, answers register reads
`timescale 1ns/100ps
module nip_phy_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       link_request,
	output logic            phy_reg_valid,
	output logic [3:0]      phy_reg_index,
	output logic [7:0]      phy_reg_value
);
	logic [15:0] sh;
	logic [4:0]  cnt;
	logic [7:0]  regs [16];
	initial foreach (regs[i]) regs[i] = 8'h30 + 8'(i);
	//==========================================================
	// frame decode, one bit a cycle, start bit high
	always @(posedge pclk or negedge presetn) begin
		phy_reg_valid <= 1'b0;
		// released lines never hold the last value, so stale data cannot pass
		phy_reg_index <= ~phy_reg_index;
		phy_reg_value <= ~phy_reg_value;
		if (!presetn) begin
			cnt <= 5'h00;
			sh  <= 16'h0000;
		end else if (cnt != 5'h00 || link_request) begin
			sh  <= {sh[14:0], link_request};
			cnt <= (cnt == 5'h0f) ? 5'h00 : cnt + 5'h01;
			if (cnt == 5'h0f && sh[13]) begin
				regs[sh[12:9]] <= sh[8:1];
			end else if (cnt == 5'h0f) begin
				phy_reg_valid <= 1'b1;
				phy_reg_index <= sh[12:9];
				phy_reg_value <= regs[sh[12:9]];
			end
		end
	end
endmodule : nip_phy_model

// [tb/testbench.sv]
// self-checking bench of the node identity and phy mailbox block
`timescale 1ns/100ps
`include "nip_map.svh"
module testbench;
	logic        pclk = 1'b0;
	logic        presetn, psel, penable, pwrite, pready, pslverr, irq, irq_a, slv;
	logic        bus_reset, self_id_done, phy_is_root, phy_cable_power_ok;
	logic        phy_reg_valid, link_request, node_id_valid;
	logic [5:0]  phy_node_number;
	logic [3:0]  phy_reg_index;
	logic [7:0]  phy_reg_value;
	logic [11:0] paddr;
	logic [15:0] node_id;
	logic [31:0] pwdata, prdata, q;
	int          mismatches, cmp_count;
	always #2 pclk = ~pclk;
	nip_node_phy_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .bus_reset(bus_reset),
		.self_id_done(self_id_done), .phy_node_number(phy_node_number),
		.phy_is_root(phy_is_root), .phy_cable_power_ok(phy_cable_power_ok),
		.phy_reg_valid(phy_reg_valid), .phy_reg_index(phy_reg_index),
		.phy_reg_value(phy_reg_value), .link_request(link_request), .node_id(node_id),
		.node_id_valid(node_id_valid), .irq(irq));
	nip_phy_model phy (.pclk(pclk), .presetn(presetn), .link_request(link_request),
		.phy_reg_valid(phy_reg_valid), .phy_reg_index(phy_reg_index),
		.phy_reg_value(phy_reg_value));
	//==========================================================
	// tasks
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : summarize
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// an idle edge first, so psel is never driven twice in one time step
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			mismatches++;
			summarize();
		end
	endtask : apb
	task automatic poll(input logic [11:0] a, input int b, input logic v);
		int n;
		n = 0;
		do begin
			apb(1'b0, a, 32'h0);
			n++;
		end while (q[b] !== v && n < 40);
		if (n >= 40) begin
			mismatches++;
			summarize();
		end
	endtask : poll
	//==========================================================
	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, bus_reset, self_id_done, phy_is_root} = '0;
		{phy_cable_power_ok, paddr, pwdata, phy_node_number} = '0;
		mismatches = 0;
		cmp_count = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `NIP_OFF_NODE_ID, 32'h0);
		chk("node reset", 32'h0000_ffff, q);
		apb(1'b0, `NIP_OFF_PHY_MBOX, 32'h0);
		chk("mailbox reset", 32'h0000_0000, q);
		phy_cable_power_ok <= 1'b1;
		apb(1'b1, `NIP_OFF_NODE_ID, 32'hffff_ab40);
		apb(1'b0, `NIP_OFF_NODE_ID, 32'h0);
		chk("node write", 32'h0800_ab7f, q);
		phy_is_root <= 1'b1;
		bus_reset <= 1'b1;
		@(posedge pclk);
		bus_reset <= 1'b0;
		apb(1'b0, `NIP_OFF_NODE_ID, 32'h0);
		chk("after bus reset", 32'h4800_ab40, q & 32'hffff_ffc0);
		phy_node_number <= 6'h05;
		self_id_done <= 1'b1;
		@(posedge pclk);
		self_id_done <= 1'b0;
		apb(1'b0, `NIP_OFF_NODE_ID, 32'h0);
		chk("after self id", 32'hc800_ab45, q);
		chk("node id out", {16'h0001, 16'hab45}, {15'h0, node_id_valid, node_id});
		apb(1'b1, `NIP_OFF_PHY_MBOX, 32'hffff_739c);
		apb(1'b0, `NIP_OFF_PHY_MBOX, 32'h0);
		chk("write pending", 32'h0000_439c, q);
		poll(`NIP_OFF_PHY_MBOX, 14, 1'b0);
		chk("write sent", 32'h0000_039c, q);
		chk("phy reg 3", 32'h0000_009c, {24'h0, phy.regs[3]});
		apb(1'b1, `NIP_OFF_PHY_MBOX, 32'h0000_8300);
		poll(`NIP_OFF_PHY_MBOX, 31, 1'b1);
		chk("read back", 32'h839c_0300, q);
		apb(1'b1, `NIP_OFF_PHY_MBOX, 32'h0000_85ff);
		apb(1'b0, `NIP_OFF_PHY_MBOX, 32'h0);
		chk("done cleared", 32'h039c_85ff, q);
		poll(`NIP_OFF_PHY_MBOX, 31, 1'b1);
		chk("second read", 32'h8535_05ff, q);
		apb(1'b1, 12'h0f0, 32'hffff_ffff);
		chk("unmapped error", 32'h1, {31'h0, slv});
		apb(1'b0, `NIP_OFF_INT_STAT, 32'h0);
		chk("int status", 32'h7, q);
		apb(1'b1, `NIP_OFF_INT_MASK, 32'h0);
		@(posedge pclk);
		irq_a = irq;
		apb(1'b1, `NIP_OFF_INT_MASK, 32'h7);
		@(posedge pclk);
		chk("irq follows mask", 32'h1, {31'h0, irq ^ irq_a});
		apb(1'b1, `NIP_OFF_INT_STAT, 32'h7);
		apb(1'b0, `NIP_OFF_INT_STAT, 32'h0);
		chk("int cleared", 32'h0, q);
		chk("irq cleared", 32'h0, {31'h0, irq});
		summarize();
	end
endmodule : testbench
